// ---- core/cos_div_if.sv ----
// Purpose: carrier between the selector and its divider
// Assumes: single clock domain
// Notes:   edges are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`include "cos_params.svh"
interface cos_div_if;
  logic                           ref_rise;
  logic                           serdes_rise;
  logic [`COS_SERDES_DIV_W-1:0]   serdes_div;
  logic                           serdes_level;
  logic                           div2;
  logic                           div4;
  logic                           serdes_clk;

  modport sel
  (
    output ref_rise,
    output serdes_rise,
    output serdes_div,
    output serdes_level,
    input  div2,
    input  div4,
    input  serdes_clk
  );
  modport div
  (
    input  ref_rise,
    input  serdes_rise,
    input  serdes_div,
    input  serdes_level,
    output div2,
    output div4,
    output serdes_clk
  );
endinterface

// ---- core/cos_params.svh ----
// Purpose: constants for the clock output select block
// Assumes: included by its bare name
// Notes:   field positions refer to the trigger output control word
`ifndef COS_PARAMS_SVH
`define COS_PARAMS_SVH

`define COS_TRIG_EN_BIT      0
`define COS_TRIG_MODE_LSB    1
`define COS_TRIG_MODE_MSB    2
`define COS_TRIG_DIV_LSB     3
`define COS_TRIG_DIV_MSB     7
`define COS_TRIG_CTRL_RST    8'h00
`define COS_REF_REPEAT_RST   1'b1
`define COS_SERDES_DIV_W     5
`define COS_SYNC_W           9

`endif

// ---- core/cos_pkg.sv ----
// Purpose: types for the clock output select block
// Assumes: nothing
// Notes:   select codes carry the field values software writes
package cos_pkg;

  typedef enum logic [1:0]
  {
    COS_AUX_OFF  = 2'h0,
    COS_AUX_REF  = 2'h1,
    COS_AUX_DIV2 = 2'h2,
    COS_AUX_DIV4 = 2'h3
  } cos_aux_sel_e;

  typedef enum logic [1:0]
  {
    COS_TRIG_OFF    = 2'h0,
    COS_TRIG_SERDES = 2'h1,
    COS_TRIG_RSVD   = 2'h2,
    COS_TRIG_STAMP  = 2'h3
  } cos_trig_mode_e;

endpackage

// ---- core/cos_ref_div.sv ----
// Purpose: edge-counting dividers for reference and serdes clocks
// Assumes: edges arrive as one-cycle pulses of sampled clocks
// Notes:   sampled clocks limit usable input rates to below clk_sys/2
`timescale 1ns/1ps
`include "cos_params.svh"
module cos_ref_div
(
  input wire logic clk_sys,
  input wire logic reset,
  cos_div_if.div   dv
);
  import cos_pkg::*;

  logic [1:0]                   ref_cnt_r;
  logic [`COS_SERDES_DIV_W-1:0] ser_cnt_r;
  logic                         ser_out_r;

  // a 2-bit counter gives /2 and /4 with even duty
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ref_cnt_r <= 2'h0;
    else if (dv.ref_rise)
      ref_cnt_r <= ref_cnt_r + 2'h1;
  end

  assign dv.div2 = ref_cnt_r[0];
  assign dv.div4 = ref_cnt_r[1];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ser_cnt_r <= '0;
    else if (dv.serdes_rise)
    begin
      if (ser_cnt_r >= dv.serdes_div - `COS_SERDES_DIV_W'(1))
        ser_cnt_r <= '0;
      else
        ser_cnt_r <= ser_cnt_r + `COS_SERDES_DIV_W'(1);
    end
  end

  // ratio 0 or 1 passes the line clock through undivided
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ser_out_r <= 1'b0;
    else if (dv.serdes_div <= `COS_SERDES_DIV_W'(1))
      ser_out_r <= dv.serdes_level;
    else
      ser_out_r <= (ser_cnt_r < (dv.serdes_div >> 1));
  end

  assign dv.serdes_clk = ser_out_r;
endmodule // cos_ref_div

// ---- core/cos_top.sv ----
// Purpose: selection and gating of the auxiliary clock outputs
// Assumes: clock inputs are sampled on clk_sys, so they run well below it
// Notes:   all outputs come from flip-flops and are low during reset
//
// Functional notes
// - The reference repeat output follows the reference input chosen.
// - Repeat output is on by default and off once software writes 0.
// - Repeat output needs pll enable high and power down low.
// - Trigger output carries retimed timestamp or serdes derived clock.
// - Trigger output stays off after reset until software enables it.
// - Serdes source is the line clock divided by the programmed ratio.
// - Aux outputs C and D run from reset per pins, off in power down.
// - With override set, select fields replace the config pins.
// - Pin codes 00,01,10,11 give off, ref, ref/2, ref/4 on output C.
// - Pins only enable output D; its ratio comes from its field.
// - Clock selection beats over-range; over-range only on quad parts.
// - Output D runs only while output C has a clock selected.
// - Reference select high picks single-ended input, low differential.
// - Trigger repeats timestamp when enabled with mode 3.
`timescale 1ns/1ps
`include "cos_params.svh"
module cos_top
#(
  parameter bit QUAD_PART = 1'b1
)
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  ref_diff_in,
  input  wire logic                  single_ended_clock_in,
  input  wire logic                  ref_input_select,
  input  wire logic                  pll_enable,
  input  wire logic                  power_down,
  input  wire logic                  timestamp_in,
  input  wire logic                  serdes_line_clk_in,
  input  wire logic [1:0]            clock_config_pins,
  input  wire logic                  ref_repeat_wr,
  input  wire logic                  ref_repeat_enable,
  input  wire logic                  trigger_ctrl_wr,
  input  wire logic [7:0]            trigger_out_control,
  input  wire logic                  pin_override_enable,
  input  wire cos_pkg::cos_aux_sel_e divided_ref_c_select,
  input  wire cos_pkg::cos_aux_sel_e divided_ref_d_select,
  input  wire logic                  overrange_enable,
  input  wire logic                  overrange_c_in,
  output logic                       ref_repeat_out,
  output logic                       trigger_clock_out,
  output logic                       aux_clock_out_c,
  output logic                       aux_clock_out_d,
  output logic                       trigger_out_active
);
  import cos_pkg::*;

  logic [`COS_SYNC_W-1:0] meta_r;
  logic [`COS_SYNC_W-1:0] sync_r;
  logic                   ref_level;
  logic                   ref_prev_r;
  logic                   ser_prev_r;
  logic                   repeat_en_r;
  logic [7:0]             trig_ctrl_r;
  logic                   pd_s;
  logic                   pll_s;
  logic                   sel_s;
  logic [1:0]             cfg_s;
  cos_aux_sel_e           c_code;
  cos_aux_sel_e           d_code;
  cos_trig_mode_e         trig_mode;
  logic                   trig_en;

  cos_div_if dv_if ();

  // every pin input except overrange_c_in passes two flops before any logic sees it
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {clock_config_pins, power_down, pll_enable,
                 ref_input_select, serdes_line_clk_in, timestamp_in,
                 single_ended_clock_in, ref_diff_in};
      sync_r <= meta_r;
    end
  end

  assign sel_s = sync_r[4];
  assign pll_s = sync_r[5];
  assign pd_s  = sync_r[6];
  assign cfg_s = sync_r[8:7];

  assign ref_level = sel_s ? sync_r[1] : sync_r[0];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ref_prev_r <= 1'b0;
      ser_prev_r <= 1'b0;
    end
    else
    begin
      ref_prev_r <= ref_level;
      ser_prev_r <= sync_r[3];
    end
  end

  // software settings, held until written again
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      repeat_en_r <= `COS_REF_REPEAT_RST;
    else if (ref_repeat_wr)
      repeat_en_r <= ref_repeat_enable;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      trig_ctrl_r <= `COS_TRIG_CTRL_RST;
    else if (trigger_ctrl_wr)
      trig_ctrl_r <= trigger_out_control;
  end

  assign trig_en   = trig_ctrl_r[`COS_TRIG_EN_BIT];
  assign trig_mode = cos_trig_mode_e'(
                     trig_ctrl_r[`COS_TRIG_MODE_MSB:`COS_TRIG_MODE_LSB]);

  assign dv_if.ref_rise     = ref_level & ~ref_prev_r;
  assign dv_if.serdes_rise  = sync_r[3] & ~ser_prev_r;
  assign dv_if.serdes_level = sync_r[3];
  assign dv_if.serdes_div   =
    trig_ctrl_r[`COS_TRIG_DIV_MSB:`COS_TRIG_DIV_LSB];

  cos_ref_div u_div
  (
    .clk_sys (clk_sys),
    .reset   (reset),
    .dv      (dv_if.div)
  );

  function automatic logic aux_pick(input cos_aux_sel_e code,
                                    input logic ref_l,
                                    input logic d2,
                                    input logic d4);
    unique case (code)
      COS_AUX_OFF:  aux_pick = 1'b0;
      COS_AUX_REF:  aux_pick = ref_l;
      COS_AUX_DIV2: aux_pick = d2;
      COS_AUX_DIV4: aux_pick = d4;
    endcase
  endfunction

  // override replaces the pins; pin codes share the field encoding
  assign c_code = pin_override_enable ? divided_ref_c_select
                                      : cos_aux_sel_e'(cfg_s);

  // pins gate output D only; a zero field falls back to plain reference
  always_comb
  begin
    d_code = COS_AUX_OFF;
    if (c_code != COS_AUX_OFF)
    begin
      if (pin_override_enable)
        d_code = divided_ref_d_select;
      else if (cfg_s != 2'h0)
        d_code = (divided_ref_d_select == COS_AUX_OFF) ? COS_AUX_REF
                                                       : divided_ref_d_select;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ref_repeat_out <= 1'b0;
    else
      ref_repeat_out <= ref_level & repeat_en_r & pll_s
                        & ~pd_s;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      aux_clock_out_c <= 1'b0;
    else if (pd_s)
      aux_clock_out_c <= 1'b0;
    else if (c_code != COS_AUX_OFF)
      aux_clock_out_c <= aux_pick(c_code, ref_level, dv_if.div2,
                                  dv_if.div4);
    else
      aux_clock_out_c <= QUAD_PART & overrange_enable
                         & overrange_c_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      aux_clock_out_d <= 1'b0;
    else
      aux_clock_out_d <= ~pd_s & aux_pick(d_code, ref_level, dv_if.div2,
                                          dv_if.div4);
  end

  // mode 2 is left unused and drives the output low
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      trigger_clock_out <= 1'b0;
    else if (!trig_en || pd_s)
      trigger_clock_out <= 1'b0;
    else
      unique case (trig_mode)
        COS_TRIG_STAMP:  trigger_clock_out <= sync_r[2];
        COS_TRIG_SERDES: trigger_clock_out <= dv_if.serdes_clk;
        COS_TRIG_OFF,
        COS_TRIG_RSVD:   trigger_clock_out <= 1'b0;
      endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      trigger_out_active <= 1'b0;
    else
      trigger_out_active <= trig_en & ~pd_s &
                            ((trig_mode == COS_TRIG_STAMP) ||
                             (trig_mode == COS_TRIG_SERDES));
  end
endmodule // cos_top

// ---- tb/clock_output_select_tb.sv ----
// Purpose: self-checking bench for the clock output select block
// Assumes: far side sources run free; rises counted over 96 cycles
// Notes:   counts packed rep, trigger, c, d from high byte down
`timescale 1ns/1ps
module clock_output_select_tb;
  import cos_pkg::*;
  logic         clk_sys = 1'b0, reset = 1'b1, power_down = 1'b0;
  logic         ref_input_select = 1'b0, pll_enable = 1'b1;
  logic [1:0]   clock_config_pins = 2'h0;
  logic         ref_repeat_wr = 1'b0, ref_repeat_enable = 1'b1;
  logic         trigger_ctrl_wr = 1'b0, overrange_c_in = 1'b0;
  logic [7:0]   trigger_out_control = 8'h00;
  logic         pin_override_enable = 1'b0, overrange_enable = 1'b0;
  cos_aux_sel_e divided_ref_c_select = COS_AUX_OFF;
  cos_aux_sel_e divided_ref_d_select = COS_AUX_OFF;
  logic         ref_diff_in, single_ended_clock_in, serdes_line_clk_in;
  logic         timestamp_in, ref_repeat_out, trigger_clock_out;
  logic         aux_clock_out_c, aux_clock_out_d, trigger_out_active;
  logic [31:0]  cnt;
  logic [7:0]   ec [4] = '{8'h00, 8'h0c, 8'h06, 8'h03};
  int           n_mismatch = 0, checked = 0;

  always #12.5 clk_sys = ~clk_sys;
  cos_far_src far (.*);
  cos_top dut (.*);

  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic wr(input logic trig, input logic [7:0] v);
    trigger_out_control = v;
    ref_repeat_enable = v[0];
    trigger_ctrl_wr = trig;
    ref_repeat_wr = !trig;
    step(1);
    trigger_ctrl_wr = 1'b0;
    ref_repeat_wr = 1'b0;
  endtask
  // whole periods only, so divider phase cannot change the count
  task automatic measure;
    logic [3:0] p, o;
    cnt = 32'h0;
    step(8);
    p = {ref_repeat_out, trigger_clock_out, aux_clock_out_c, aux_clock_out_d};
    repeat (96)
    begin
      step(1);
      o = {ref_repeat_out, trigger_clock_out,
           aux_clock_out_c, aux_clock_out_d};
      for (int i = 0; i < 4; i++)
        if (o[i] === 1'b1 && p[i] === 1'b0)
          cnt[8*i +: 8] = cnt[8*i +: 8] + 8'h01;
      // an unknown output must not pass as a zero count
      if ($isunknown(o))
        cnt = 32'hxxxxxxxx;
      p = o;
    end
  endtask
  task automatic t_repeat;
    measure();
    check(cnt, 32'h0c000000);
    ref_input_select = 1'b1;
    measure();
    check(cnt, 32'h10000000);
    ref_input_select = 1'b0;
    wr(1'b0, 8'h00);
    measure();
    check(cnt, 32'h00000000);
    wr(1'b0, 8'h01);
    pll_enable = 1'b0;
    measure();
    check(cnt, 32'h00000000);
    pll_enable = 1'b1;
  endtask
  task automatic t_trig;
    wr(1'b1, 8'h07);
    measure();
    check(cnt, 32'h0c060000);
    check({31'h0, trigger_out_active}, 32'h1);
    wr(1'b1, 8'h1b);
    measure();
    check(cnt, 32'h0c080000);
    // ratio zero passes the line clock straight through
    wr(1'b1, 8'h03);
    measure();
    check(cnt, 32'h0c180000);
    check({31'h0, trigger_out_active}, 32'h1);
    wr(1'b1, 8'h01);
    measure();
    check(cnt, 32'h0c000000);
    check({31'h0, trigger_out_active}, 32'h0);
    wr(1'b1, 8'h05);
    measure();
    check(cnt, 32'h0c000000);
    check({31'h0, trigger_out_active}, 32'h0);
  endtask
  task automatic t_aux;
    for (int i = 0; i < 4; i++)
    begin
      clock_config_pins = 2'(i);
      measure();
      check(cnt, {16'h0c00, ec[i], (i > 0) ? 8'h0c : 8'h00});
    end
    divided_ref_d_select = COS_AUX_DIV2;
    measure();
    check(cnt, 32'h0c000306);
    clock_config_pins = 2'h0;
    pin_override_enable = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      divided_ref_c_select = cos_aux_sel_e'(i);
      measure();
      check(cnt, {16'h0c00, ec[i], (i > 0) ? 8'h06 : 8'h00});
    end
    divided_ref_c_select = COS_AUX_OFF;
    overrange_enable = 1'b1;
    overrange_c_in = 1'b1;
    step(6);
    check({31'h0, aux_clock_out_c}, 32'h1);
    divided_ref_c_select = COS_AUX_REF;
    measure();
    check(cnt, 32'h0c000c06);
    // with override on, a zero d field keeps output d quiet
    divided_ref_d_select = COS_AUX_OFF;
    measure();
    check(cnt, 32'h0c000c00);
    divided_ref_d_select = COS_AUX_DIV2;
  endtask
  task automatic t_pd;
    wr(1'b1, 8'h07);
    power_down = 1'b1;
    measure();
    check(cnt, 32'h00000000);
    power_down = 1'b0;
    measure();
    check(cnt, 32'h0c060c06);
  endtask

  initial
  begin
    step(20);
    reset = 1'b0;
    t_repeat();
    t_trig();
    t_aux();
    t_pd();
    stop_test();
  end
  initial
  begin
    step(20000);
    n_mismatch++;
    stop_test();
  end
endmodule // clock_output_select_tb

// ---- tb/cos_far_src.sv ----
// Purpose: far side clock sources for the clock output select block
// Assumes: all rates are well below clk_sys/2
// Notes:   periods 8, 6, 4 and 16 cycles fit a 96-cycle window
`timescale 1ns/1ps
module cos_far_src
(
  input  wire logic clk_sys,
  output logic      ref_diff_in,
  output logic      single_ended_clock_in,
  output logic      serdes_line_clk_in,
  output logic      timestamp_in
);
  logic [3:0] cnt_r = 4'h0;
  logic [2:0] se_r  = 3'h0;
  always @(posedge clk_sys)
  begin
    cnt_r <= #1 cnt_r + 4'h1;
    se_r  <= #1 (se_r == 3'h5) ? 3'h0 : se_r + 3'h1;
  end
  assign ref_diff_in           = cnt_r[2];
  assign serdes_line_clk_in    = cnt_r[1];
  assign timestamp_in          = cnt_r[3];
  assign single_ended_clock_in = (se_r > 3'h2);
endmodule // cos_far_src

// ---- tb/cos_props.sv ----
// Purpose: port assertions for the clock output select block
// Assumes: pins need two sync edges plus an output flop
// Notes:   helpers mirror the two software write strobes
`timescale 1ns/1ps
module cos_props
#(
  parameter bit QUAD_PART = 1'b1
)
(
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire logic                  ref_diff_in,
  input wire logic                  ref_input_select,
  input wire logic                  pll_enable,
  input wire logic                  power_down,
  input wire logic                  timestamp_in,
  input wire logic [1:0]            clock_config_pins,
  input wire logic                  ref_repeat_wr,
  input wire logic                  ref_repeat_enable,
  input wire logic                  trigger_ctrl_wr,
  input wire logic [7:0]            trigger_out_control,
  input wire logic                  pin_override_enable,
  input wire cos_pkg::cos_aux_sel_e divided_ref_c_select,
  input wire logic                  overrange_enable,
  input wire logic                  overrange_c_in,
  input wire logic                  ref_repeat_out,
  input wire logic                  trigger_clock_out,
  input wire logic                  aux_clock_out_c,
  input wire logic                  aux_clock_out_d,
  input wire logic                  trigger_out_active
);
  import cos_pkg::*;
  logic       rep_en_r;
  logic [7:0] trig_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      rep_en_r <= 1'b1;
    else if (ref_repeat_wr)
      rep_en_r <= ref_repeat_enable;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      trig_r <= 8'h00;
    else if (trigger_ctrl_wr)
      trig_r <= trigger_out_control;
  end
  wire ref_ok   = rep_en_r && pll_enable && !power_down && !ref_input_select;
  wire stamp_ok = trig_r[2:0] == 3'h7 && !trigger_ctrl_wr && !power_down;
  wire c_pin_ok = !pin_override_enable && !power_down && !ref_input_select
                  && clock_config_pins == 2'h1;
  wire ovr_ok   = pin_override_enable && divided_ref_c_select == COS_AUX_OFF
                  && overrange_enable && !power_down;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // pins and strobes must hold while the sample runs down the pipe
  sequence s_ref_held;
    ref_ok && !ref_repeat_wr ##1 !ref_repeat_wr [*2];
  endsequence
  sequence s_pin_held;
    c_pin_ok ##1 !pin_override_enable [*2];
  endsequence
  chk_ref_follow: assert property
    (s_ref_held |=> ref_repeat_out == $past(ref_diff_in, 3))
    else $error("repeat output not following reference");
  chk_rep_off: assert property
    ((!rep_en_r) [*3] |-> !ref_repeat_out) else $error("repeat not off");
  chk_pd_off: assert property
    (power_down |-> ##3 !(ref_repeat_out || trigger_clock_out
      || aux_clock_out_c || aux_clock_out_d)) else $error("pd not gating");
  chk_trig_off: assert property
    ((!trig_r[0]) [*3] |-> !trigger_clock_out && !trigger_out_active)
    else $error("trigger output live while disabled");
  chk_trig_stamp: assert property
    (stamp_ok [*3] |=> trigger_clock_out == $past(timestamp_in, 3))
    else $error("trigger not repeating timestamp");
  chk_aux_pin: assert property
    (s_pin_held |=> aux_clock_out_c == $past(ref_diff_in, 3))
    else $error("output c not reference");
  chk_ovr_c: assert property
    (ovr_ok [*4] |=> aux_clock_out_c == (QUAD_PART && $past(overrange_c_in)))
    else $error("output c not over-range");
  chk_d_needs_c: assert property
    ((pin_override_enable && divided_ref_c_select == COS_AUX_OFF) [*3]
      |-> !aux_clock_out_d) else $error("output d live with c off");
endmodule // cos_props

bind cos_top cos_props #(.QUAD_PART(QUAD_PART)) u_props (.*);
